// *** slc_pkg.sv ***
// Shared constants and types for the serial link transmitter control bank.
// Assumes registers are 8 bits wide, one per 32-bit Wishbone word.
package slc_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [9:0] SOFT_SYNC_IDX = 10'h203;
    localparam logic [9:0] LINK_CTRL_IDX = 10'h204;
    localparam logic [9:0] TEST_CTRL_IDX = 10'h205;
    localparam logic [9:0] LINK_CFG_IDX = 10'h210;
    localparam logic [9:0] LINK_STAT_IDX = 10'h211;

    // Reset values
    localparam logic [7:0] SOFT_SYNC_RST = 8'h01;
    localparam logic [7:0] LINK_CTRL_RST = 8'h03;
    localparam logic [7:0] TEST_CTRL_RST = 8'h00;
    localparam logic [7:0] LINK_CFG_RST = 8'h01;

    // Writable bits; reserved bits stay zero
    localparam logic [7:0] SOFT_SYNC_MASK = 8'h01;
    localparam logic [7:0] LINK_CTRL_MASK = 8'h1F;
    localparam logic [7:0] TEST_CTRL_MASK = 8'h1F;
    localparam logic [7:0] LINK_CFG_MASK = 8'h07;

    // Field positions
    localparam int SOFT_SYNC_BIT = 0;
    localparam int SCRAMBLER_BIT = 0;
    localparam int FORMAT_BIT = 1;
    localparam int SYNC_SEL_LSB = 2;
    localparam int SYNC_SEL_MSB = 3;
    localparam int UPPER_LANE_BIT = 4;
    localparam int TEST_LSB = 0;
    localparam int TEST_MSB = 4;
    localparam int CFG_ENABLE_BIT = 0;
    localparam int CFG_64B66B_BIT = 1;
    localparam int CFG_TS_RX_BIT = 2;

    // Lane mapping
    localparam int MAX_LANES = 8;
    localparam logic [3:0] UPPER_LANE_BASE = 4'h4;

    // Fixed serial words
    localparam logic [15:0] WORD_LOW = 16'h0000;
    localparam logic [15:0] WORD_HIGH = 16'hFFFF;
    localparam logic [15:0] WORD_CLOCK = 16'h00FF;

    typedef enum logic [1:0] {
        SYNC_SINGLE = 2'h0,
        SYNC_STAMP = 2'h1,
        SYNC_SOFT = 2'h2,
        SYNC_SPARE = 2'h3
    } slc_sync_src_e;

    typedef enum logic [4:0] {
        PAT_NORMAL = 5'h00,
        PAT_PRBS7 = 5'h01,
        PAT_PRBS15 = 5'h02,
        PAT_PRBS23 = 5'h03,
        PAT_RAMP = 5'h04,
        PAT_TRANSPORT = 5'h05,
        PAT_D21_5 = 5'h06,
        PAT_K28_5 = 5'h07,
        PAT_ILA = 5'h08,
        PAT_RPAT = 5'h09,
        PAT_LOW = 5'h0A,
        PAT_HIGH = 5'h0B,
        PAT_PRBS9 = 5'h0D,
        PAT_PRBS31 = 5'h0E,
        PAT_CLOCK = 5'h0F,
        PAT_K28_7 = 5'h10
    } slc_pattern_e;

endpackage : slc_pkg

// *** slc_sync_select.sv ***
// Sync source selection and the effective synchronization request.
// Assumes sync pins are active low and already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module slc_sync_select (
    input wire logic clk,
    input wire logic reset,
    input wire logic softSyncN,
    input wire logic [1:0] syncSource,
    input wire logic tsReceiverEnable,
    input wire logic singleEndedSyncPinN,
    input wire logic timestampPinPairN,
    output logic syncRequest
);

    slc_pkg::slc_sync_src_e source;
    logic singleReq;
    logic stampReq;
    logic pinReq;
    logic requestD;

    // Pin selection; a disabled stamp receiver never requests
    assign source = slc_pkg::slc_sync_src_e'(syncSource);
    assign singleReq = !singleEndedSyncPinN;
    assign stampReq = tsReceiverEnable && !timestampPinPairN;
    assign pinReq = (source == slc_pkg::SYNC_SINGLE) ? singleReq :
                    (source == slc_pkg::SYNC_STAMP) ? stampReq : 1'b0;
    // Soft request ORs in for every source setting
    assign requestD = !softSyncN || pinReq;

    always_ff @(posedge clk) begin
        if (reset) begin
            syncRequest <= 1'b0;
        end else begin
            syncRequest <= requestD;
        end
    end

    // Software request wins whatever source is chosen
    soft_sync_a: assert property (@(posedge clk) disable iff (reset)
        !softSyncN |=> syncRequest)
        else $error("soft sync did not raise request");

    // A low selected pin cannot be overridden by the soft bit
    pin_hold_a: assert property (@(posedge clk) disable iff (reset)
        (source == slc_pkg::SYNC_SINGLE) && !singleEndedSyncPinN && softSyncN |=> syncRequest)
        else $error("low sync pin request dropped");

    // Stamp pair drives the request when selected
    stamp_src_a: assert property (@(posedge clk) disable iff (reset)
        (source == slc_pkg::SYNC_STAMP) && tsReceiverEnable && !timestampPinPairN |=> syncRequest)
        else $error("stamp pair request missed");

    // Soft source ignores both pins
    soft_only_a: assert property (@(posedge clk) disable iff (reset)
        (source == slc_pkg::SYNC_SOFT) && softSyncN |=> !syncRequest)
        else $error("pin leaked through soft source");

endmodule : slc_sync_select

`default_nettype wire

// *** slc_pattern_decode.sv ***
// Test field decode into a pattern selection and a fixed serial word.
// Assumes the field and the encoding choice are held steady while the link is on.
`timescale 1ns/100ps
`default_nettype none

module slc_pattern_decode (
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] testCode,
    input wire logic mode64b66b,
    output slc_pkg::slc_pattern_e patternMode,
    output logic [15:0] levelWord
);

    logic reservedCode;
    logic only8b10b;
    logic legalCode;
    slc_pkg::slc_pattern_e modeD;
    logic [15:0] wordD;

    // Reserved codes, and 8B/10B-only codes in 64B/66B mode, fall back to normal data
    assign reservedCode = (testCode == 5'h0C) || (testCode > 5'h10);
    assign only8b10b = (testCode == 5'h07) || (testCode == 5'h08) ||
                       (testCode == 5'h09) || (testCode == 5'h10);
    assign legalCode = !reservedCode && !(mode64b66b && only8b10b);
    assign modeD = legalCode ? slc_pkg::slc_pattern_e'(testCode) : slc_pkg::PAT_NORMAL;
    // Constant levels and the clock word on the serial outputs
    assign wordD = (modeD == slc_pkg::PAT_HIGH) ? slc_pkg::WORD_HIGH :
                   (modeD == slc_pkg::PAT_CLOCK) ? slc_pkg::WORD_CLOCK : slc_pkg::WORD_LOW;

    always_ff @(posedge clk) begin
        if (reset) begin
            patternMode <= slc_pkg::PAT_NORMAL;
            levelWord <= slc_pkg::WORD_LOW;
        end else begin
            patternMode <= modeD;
            levelWord <= wordD;
        end
    end

    // 8B/10B-only patterns are refused in 64B/66B mode
    only_8b10b_a: assert property (@(posedge clk) disable iff (reset)
        mode64b66b && only8b10b |=> patternMode == slc_pkg::PAT_NORMAL)
        else $error("8b10b-only pattern offered in 64b66b mode");

    // Clock word appears one cycle after code 15
    clock_word_a: assert property (@(posedge clk) disable iff (reset)
        testCode == 5'h0F |=> levelWord == 16'h00FF && patternMode == slc_pkg::PAT_CLOCK)
        else $error("clock pattern word wrong");

    // PRBS31 selection
    prbs_sel_a: assert property (@(posedge clk) disable iff (reset)
        testCode == 5'h0E |=> patternMode == slc_pkg::PAT_PRBS31)
        else $error("prbs31 not selected");

endmodule : slc_pattern_decode

`default_nettype wire

// *** slc_link_regs.sv ***
// Wishbone register bank steering the serial link transmitter controls.
// Assumes a classic Wishbone master on clk; pins and laneCount are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Soft sync bit at zero raises a sync request; reset value one.
// - Soft sync bit requests regardless of the sync source field.
// - A low selected pin keeps the request; only source 2 frees it. The code frees it for source 3 as well.
// - Upper-lane bit zero drives lanes 0 to L-1.
// - Upper-lane bit one drives lanes 4 to 4+L-1, lanes 0-3 idle.
// - Sync source field at bits 3:2; zero takes the single-ended pin.
// - Source one takes the timestamp pair; software enables its receiver.
// - Source two ignores pins and uses only the soft sync bit.
// - Format bit zero gives offset binary, one two's complement; reset one.
// - In 8B/10B modes the scrambler bit turns scrambling on; reset one.
// - In 64B/66B modes scrambling is always on.
// - Test field bits 4:0 select PRBS7/15/23/9/31; zero is normal.
// - Test values 4, 5, 6 give ramp, transport and D21.5 patterns.
// - Test values 7, 8, 9, 16 are offered only in 8B/10B modes.
// - Test value 10 holds outputs low, 11 holds them high.
// - Test value 15 sends the repeating 0x00FF clock word.
// - Link disabled holds transmitter in reset, powered down, ignoring SYSREF.
module slc_link_regs #(
    parameter int MAX_LANES = slc_pkg::MAX_LANES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic singleEndedSyncPinN,
    input wire logic timestampPinPairN,
    input wire logic [3:0] laneCount,
    input wire logic sysrefIn,
    output logic syncRequest,
    output logic [MAX_LANES-1:0] laneEnable,
    output logic linkReset,
    output logic serializerPowerDown,
    output logic linkClockEnable,
    output logic sysrefToCounter,
    output logic sampleTwosComplement,
    output logic scramblerOn,
    output slc_pkg::slc_pattern_e patternMode,
    output logic [15:0] levelWord
);

    // Stored registers, reserved bits held at zero
    logic [7:0] softSync_q;
    logic [7:0] linkCtrl_q;
    logic [7:0] testCtrl_q;
    logic [7:0] linkCfg_q;

    // Bus handshake state
    logic ack_q;
    logic [31:0] rdData_q;

    // Registered control outputs and their next-state values
    logic [MAX_LANES-1:0] laneEnable_q;
    logic [MAX_LANES-1:0] laneEnable_d;
    logic linkReset_q;
    logic powerDown_q;
    logic clockEnable_q;
    logic sysrefGate_q;
    logic twosComp_q;
    logic scrambler_q;
    logic scrambler_d;

    // Address decode and bus qualifiers
    logic [9:0] wordIndex;
    logic hitSoft;
    logic hitCtrl;
    logic hitTest;
    logic hitCfg;
    logic hitStat;
    logic reqValid;
    logic wrStrobe;
    logic [7:0] wrByte;
    logic [7:0] statusByte;
    logic [7:0] readByte;

    // Field views
    logic softSyncN;
    logic upperLane;
    logic [1:0] syncSource;
    logic formatBit;
    logic scramblerBit;
    logic [4:0] testCode;
    logic linkEnable;
    logic mode64b66b;
    logic tsReceiverEnable;

    // Decode from word index; byte lane 0 carries all register data
    assign wordIndex = wb_adr_i[11:2];
    assign hitSoft = wordIndex == slc_pkg::SOFT_SYNC_IDX;
    assign hitCtrl = wordIndex == slc_pkg::LINK_CTRL_IDX;
    assign hitTest = wordIndex == slc_pkg::TEST_CTRL_IDX;
    assign hitCfg = wordIndex == slc_pkg::LINK_CFG_IDX;
    assign hitStat = wordIndex == slc_pkg::LINK_STAT_IDX;

    // Write lands at the edge the master sees ack, never twice
    assign reqValid = wb_cyc_i && wb_stb_i && !ack_q;
    assign wrStrobe = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
    assign wrByte = wb_dat_i[7:0];

    // Field extraction
    assign softSyncN = softSync_q[slc_pkg::SOFT_SYNC_BIT];
    assign upperLane = linkCtrl_q[slc_pkg::UPPER_LANE_BIT];
    assign syncSource = linkCtrl_q[slc_pkg::SYNC_SEL_MSB:slc_pkg::SYNC_SEL_LSB];
    assign formatBit = linkCtrl_q[slc_pkg::FORMAT_BIT];
    assign scramblerBit = linkCtrl_q[slc_pkg::SCRAMBLER_BIT];
    assign testCode = testCtrl_q[slc_pkg::TEST_MSB:slc_pkg::TEST_LSB];
    assign linkEnable = linkCfg_q[slc_pkg::CFG_ENABLE_BIT];
    assign mode64b66b = linkCfg_q[slc_pkg::CFG_64B66B_BIT];
    assign tsReceiverEnable = linkCfg_q[slc_pkg::CFG_TS_RX_BIT];

    // Status shows live block state; unmapped words read zero
    assign statusByte = {5'h00, linkEnable, scrambler_q, syncRequest};
    assign readByte = hitSoft ? softSync_q :
                      hitCtrl ? linkCtrl_q :
                      hitTest ? testCtrl_q :
                      hitCfg ? linkCfg_q :
                      hitStat ? statusByte : 8'h00;

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q <= 1'b0;
            rdData_q <= 32'h00000000;
        end else begin
            ack_q <= reqValid;
            rdData_q <= {24'h000000, readByte};
        end
    end

    // Soft sync register
    always_ff @(posedge clk) begin
        if (reset) begin
            softSync_q <= slc_pkg::SOFT_SYNC_RST;
        end else if (wrStrobe && hitSoft) begin
            softSync_q <= wrByte & slc_pkg::SOFT_SYNC_MASK;
        end
    end

    // Lane map, sync source, format and scrambler register
    always_ff @(posedge clk) begin
        if (reset) begin
            linkCtrl_q <= slc_pkg::LINK_CTRL_RST;
        end else if (wrStrobe && hitCtrl) begin
            linkCtrl_q <= wrByte & slc_pkg::LINK_CTRL_MASK;
        end
    end

    // Test pattern register
    always_ff @(posedge clk) begin
        if (reset) begin
            testCtrl_q <= slc_pkg::TEST_CTRL_RST;
        end else if (wrStrobe && hitTest) begin
            testCtrl_q <= wrByte & slc_pkg::TEST_CTRL_MASK;
        end
    end

    // Link enable, encoding and stamp receiver register
    always_ff @(posedge clk) begin
        if (reset) begin
            linkCfg_q <= slc_pkg::LINK_CFG_RST;
        end else if (wrStrobe && hitCfg) begin
            linkCfg_q <= wrByte & slc_pkg::LINK_CFG_MASK;
        end
    end

    // Per-lane enable; counts above four in upper mode are left to software
    generate
        for (genvar i = 0; i < MAX_LANES; i++) begin : g_lane
            localparam logic [3:0] LANE = 4'(i);
            logic normalUse;
            logic upperUse;
            assign normalUse = LANE < laneCount;
            assign upperUse = (LANE >= slc_pkg::UPPER_LANE_BASE) &&
                              ((LANE - slc_pkg::UPPER_LANE_BASE) < laneCount);
            assign laneEnable_d[i] = linkEnable && (upperLane ? upperUse : normalUse);
        end
    endgenerate

    // 64B/66B always scrambles; the bit only matters for 8B/10B
    assign scrambler_d = mode64b66b || scramblerBit;

    // Link gating; disabled link blocks SYSREF from the multiframe counter
    always_ff @(posedge clk) begin
        if (reset) begin
            laneEnable_q <= '0;
            linkReset_q <= 1'b1;
            powerDown_q <= 1'b1;
            clockEnable_q <= 1'b0;
            sysrefGate_q <= 1'b0;
        end else begin
            laneEnable_q <= laneEnable_d;
            linkReset_q <= !linkEnable;
            powerDown_q <= !linkEnable;
            clockEnable_q <= linkEnable;
            sysrefGate_q <= linkEnable && sysrefIn;
        end
    end

    // Sample format and scrambler outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            twosComp_q <= 1'b1;
            scrambler_q <= 1'b1;
        end else begin
            twosComp_q <= formatBit;
            scrambler_q <= scrambler_d;
        end
    end

    // Effective synchronization request
    slc_sync_select u_sync (
        .clk(clk),
        .reset(reset),
        .softSyncN(softSyncN),
        .syncSource(syncSource),
        .tsReceiverEnable(tsReceiverEnable),
        .singleEndedSyncPinN(singleEndedSyncPinN),
        .timestampPinPairN(timestampPinPairN),
        .syncRequest(syncRequest)
    );

    // Test pattern selection
    slc_pattern_decode u_pattern (
        .clk(clk),
        .reset(reset),
        .testCode(testCode),
        .mode64b66b(mode64b66b),
        .patternMode(patternMode),
        .levelWord(levelWord)
    );

    // Output wiring from flops
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;
    assign laneEnable = laneEnable_q;
    assign linkReset = linkReset_q;
    assign serializerPowerDown = powerDown_q;
    assign linkClockEnable = clockEnable_q;
    assign sysrefToCounter = sysrefGate_q;
    assign sampleTwosComplement = twosComp_q;
    assign scramblerOn = scrambler_q;

    // Ack is a single-cycle pulse per request
    bus_ack_a: assert property (@(posedge clk) disable iff (reset)
        reqValid |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse");

    // Writing zero to soft sync reaches the request two edges later
    soft_write_a: assert property (@(posedge clk) disable iff (reset)
        wrStrobe && hitSoft && !wrByte[0] |=> ##1 syncRequest)
        else $error("soft sync write did not request");

    // Normal mapping with two lanes; sampled reset keeps the release edge out
    lane_normal_a: assert property (@(posedge clk) disable iff (reset)
        !reset && linkEnable && !upperLane && laneCount == 4'h2 |=> laneEnable == 8'h03)
        else $error("normal lane map wrong");

    // Upper mapping with two lanes leaves lanes 0 to 3 idle
    lane_upper_a: assert property (@(posedge clk) disable iff (reset)
        linkEnable && upperLane && laneCount == 4'h2 |=> laneEnable == 8'h30)
        else $error("upper lane map wrong");

    // Disabled link is reset, powered down and deaf to SYSREF
    link_off_a: assert property (@(posedge clk) disable iff (reset)
        !linkEnable |=> linkReset && serializerPowerDown && !linkClockEnable &&
                        laneEnable == 8'h00 && !sysrefToCounter)
        else $error("disabled link not held off");

    // SYSREF passes only while enabled; release edge still shows reset outputs
    sysref_pass_a: assert property (@(posedge clk) disable iff (reset)
        !reset && linkEnable && sysrefIn |=> sysrefToCounter)
        else $error("sysref not passed");

    // Format output follows the bit
    format_a: assert property (@(posedge clk) disable iff (reset)
        ##1 sampleTwosComplement == $past(formatBit))
        else $error("sample format mismatch");

    // 64B/66B forces scrambling
    scramble_64_a: assert property (@(posedge clk) disable iff (reset)
        mode64b66b |=> scramblerOn)
        else $error("64b66b not scrambled");

    // 8B/10B honours a cleared scrambler bit
    scramble_8b_a: assert property (@(posedge clk) disable iff (reset)
        !mode64b66b && !scramblerBit |=> !scramblerOn)
        else $error("8b10b scrambler not off");

    // Held-low pattern drives a zero word
    held_low_a: assert property (@(posedge clk) disable iff (reset)
        testCode == 5'h0A |=> levelWord == 16'h0000 && patternMode == slc_pkg::PAT_LOW)
        else $error("held low pattern wrong");

    // Ramp selection
    ramp_sel_a: assert property (@(posedge clk) disable iff (reset)
        testCode == 5'h04 |=> patternMode == slc_pkg::PAT_RAMP)
        else $error("ramp not selected");

    // Upper mapping never drives the low four lanes
    lane_idle_a: assert property (@(posedge clk) disable iff (reset)
        linkEnable && upperLane |=> laneEnable[3:0] == 4'h0)
        else $error("low lanes driven in upper map");

    // 8B/10B honours a set scrambler bit
    scramble_on_a: assert property (@(posedge clk) disable iff (reset)
        !mode64b66b && scramblerBit |=> scramblerOn)
        else $error("8b10b scrambler not on");

    // Enabled link leaves reset and powers up; release edge left out
    link_on_a: assert property (@(posedge clk) disable iff (reset)
        !reset && linkEnable |=> !linkReset && !serializerPowerDown && linkClockEnable)
        else $error("enabled link still held off");

    // Read data carries zeros above byte lane 0
    rd_upper_a: assert property (@(posedge clk) disable iff (reset)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bytes not zero");

endmodule : slc_link_regs

`default_nettype wire

// *** slc_sync_receiver.sv ***
// Far-end receiver model that drives the two active-low sync pins.
// Assumes the bench changes the hold flags right after a rising edge.
`timescale 1ns/100ps
`default_nettype none

module slc_sync_receiver (
    input wire logic clk,
    input wire logic holdSingle,
    input wire logic holdStamp,
    output logic singleEndedSyncPinN,
    output logic timestampPinPairN
);
    // Pins idle high as if pulled up; low while resync is wanted
    always @(posedge clk) begin
        singleEndedSyncPinN <= ~holdSingle;
        timestampPinPairN <= ~holdStamp;
    end
endmodule : slc_sync_receiver

`default_nettype wire

// *** slc_link_regs_tb.sv ***
// Self-checking bench for the link control register bank.
// Assumes classic Wishbone with a one-cycle ack and registered outputs.
`timescale 1ns/100ps
`default_nettype none

module slc_link_regs_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [11:0] wbAdr = 12'h000;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDat = 32'h00000000;
    logic [31:0] wbDatO;
    logic wbAck;
    logic holdSingle = 1'b0;
    logic holdStamp = 1'b0;
    logic seN;
    logic tsN;
    logic [3:0] laneCount = 4'h2;
    logic sysrefIn = 1'b1;
    logic syncRequest;
    logic [7:0] laneEnable;
    logic linkReset;
    logic powerDown;
    logic clockEnable;
    logic sysrefOut;
    logic twosComp;
    logic scramblerOn;
    slc_pkg::slc_pattern_e patternMode;
    logic [15:0] levelWord;
    int fail_count = 0;
    int num_checks = 0;

    slc_link_regs i_slc_link_regs (
        .clk(clk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .singleEndedSyncPinN(seN), .timestampPinPairN(tsN), .laneCount(laneCount),
        .sysrefIn(sysrefIn), .syncRequest(syncRequest), .laneEnable(laneEnable),
        .linkReset(linkReset), .serializerPowerDown(powerDown), .linkClockEnable(clockEnable),
        .sysrefToCounter(sysrefOut), .sampleTwosComplement(twosComp), .scramblerOn(scramblerOn),
        .patternMode(patternMode), .levelWord(levelWord)
    );

    slc_sync_receiver i_slc_sync_receiver (
        .clk(clk), .holdSingle(holdSingle), .holdStamp(holdStamp),
        .singleEndedSyncPinN(seN), .timestampPinPairN(tsN)
    );

    // Free-running 125 MHz clock
    always #4 clk = ~clk;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // One classic cycle; holds the request until ack is sampled
    task wbCycle(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbSel <= 4'hF;
        wbDat <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        if (n >= 50) check(32'h00000000, 32'h00000001);
        @(posedge clk);
    endtask : wbCycle

    task wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        wbCycle(a, 1'b1, d, q);
    endtask : wr

    task rdChk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wbCycle(a, 1'b0, 8'h00, q);
        check(q, exp);
    endtask : rdChk

    // Outputs are registered, pins pass through the partner first
    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task testReset;
        rdChk(12'h80C, 32'h00000001);
        rdChk(12'h810, 32'h00000003);
        rdChk(12'h814, 32'h00000000);
        rdChk(12'h0FC, 32'h00000000);
        rdChk(12'h840, 32'h00000001);
        rdChk(12'h844, 32'h00000006);
        check(twosComp, 32'h00000001);
        check(scramblerOn, 32'h00000001);
        check(syncRequest, 32'h00000000);
        $display("reset values done");
    endtask : testReset

    task testLanes;
        wr(12'h810, 8'h03);
        settle;
        check(laneEnable, 32'h00000003);
        wr(12'h810, 8'h13);
        settle;
        check(laneEnable, 32'h00000030);
        laneCount <= 4'h4;
        settle;
        check(laneEnable, 32'h000000F0);
        rdChk(12'h810, 32'h00000013);
        laneCount <= 4'h2;
        wr(12'h810, 8'h03);
        $display("lane mapping done");
    endtask : testLanes

    task testSync;
        for (int s = 0; s < 3; s++) begin
            wr(12'h80C, 8'h00);
            wr(12'h810, {4'h0, 2'(s), 2'h3});
            settle;
            check(syncRequest, 32'h00000001);
        end
        wr(12'h80C, 8'h01);
        wr(12'h810, 8'h03);
        holdStamp <= 1'b1;
        settle;
        check(syncRequest, 32'h00000000);
        holdStamp <= 1'b0;
        holdSingle <= 1'b1;
        settle;
        check(syncRequest, 32'h00000001);
        wr(12'h810, 8'h0B);
        settle;
        check(syncRequest, 32'h00000000);
        wr(12'h80C, 8'h00);
        settle;
        check(syncRequest, 32'h00000001);
        wr(12'h80C, 8'h01);
        holdSingle <= 1'b0;
        wr(12'h840, 8'h05);
        wr(12'h810, 8'h07);
        holdStamp <= 1'b1;
        settle;
        check(syncRequest, 32'h00000001);
        holdStamp <= 1'b0;
        settle;
        check(syncRequest, 32'h00000000);
        wr(12'h840, 8'h01);
        wr(12'h810, 8'h03);
        $display("sync source done");
    endtask : testSync

    // Link is switched off before scrambler or test changes
    task testControl;
        settle;
        check(sysrefOut, 32'h00000001);
        wr(12'h840, 8'h00);
        settle;
        check(linkReset, 32'h00000001);
        check(powerDown, 32'h00000001);
        check(clockEnable, 32'h00000000);
        check(sysrefOut, 32'h00000000);
        wr(12'h810, 8'h00);
        settle;
        check(twosComp, 32'h00000000);
        check(scramblerOn, 32'h00000000);
        wr(12'h840, 8'h02);
        settle;
        check(scramblerOn, 32'h00000001);
        wr(12'h840, 8'h00);
        wr(12'h810, 8'h03);
        $display("link control done");
    endtask : testControl

    task testPatterns;
        logic [15:0] lv;
        for (int c = 0; c < 17; c++) begin
            if (c != 12) begin
                wr(12'h814, 8'(c));
                settle;
                lv = (c == 11) ? 16'hFFFF : (c == 15) ? 16'h00FF : 16'h0000;
                check(patternMode, 32'(c));
                check(levelWord, {16'h0000, lv});
            end
        end
        wr(12'h840, 8'h02);
        for (int c = 8; c < 10; c++) begin
            wr(12'h814, 8'(c));
            settle;
            check(patternMode, 32'h00000000);
        end
        wr(12'h814, 8'h10);
        settle;
        check(patternMode, 32'h00000000);
        wr(12'h814, 8'h07);
        settle;
        check(patternMode, 32'h00000000);
        wr(12'h814, 8'h0E);
        settle;
        check(patternMode, 32'h0000000E);
        wr(12'h814, 8'h00);
        wr(12'h840, 8'h01);
        $display("test patterns done");
    endtask : testPatterns

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // Main sequence after an 8-cycle reset
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        testReset;
        testLanes;
        testSync;
        testControl;
        testPatterns;
        stop_test;
    end

    // Watchdog well beyond the expected run
    initial begin
        #300000;
        fail_count++;
        stop_test;
    end
endmodule : slc_link_regs_tb

`default_nettype wire
